// File: design/pcl_port_ctrl.sv
`timescale 1ns/100ps
`include "pcl_consts.svh"

module pcl_port_ctrl #(
    parameter int PORT_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // processor bus
    input wire pcl_pkg::pcl_bus_t bus,
    output logic [7:0] busRdData,
    // side A port pins
    input wire logic [7:0] portAIn,
    output logic [7:0] portAOut,
    output logic [7:0] portAOe,
    // side B port pins
    input wire logic [7:0] portBIn,
    output logic [7:0] portBOut,
    output logic [7:0] portBOe,
    // side A control lines
    input wire logic sideAIrqInput,
    input wire logic sideACtrlLineIn,
    output logic sideACtrlLineOut,
    output logic sideACtrlLineOe,
    // side B control lines
    input wire logic sideBIrqInput,
    input wire logic sideBCtrlLineIn,
    output logic sideBCtrlLineOut,
    output logic sideBCtrlLineOe,
    // open-drain interrupt requests, active low
    output logic sideAIntRequestOut,
    output logic sideAIntRequestOe,
    output logic sideBIntRequestOut,
    output logic sideBIntRequestOe
);

    // ==========================================
    // elaboration check
    // the bus and all registers are byte wide; other widths are not served
    if (PORT_W != 8) begin : g_bad_width
        $error("pcl_port_ctrl: PORT_W must be 8");
    end

    // ==========================================
    // helpers
    function automatic logic edgeHit(
        input logic prev,
        input logic cur,
        input logic rising
    );
        edgeHit = rising ? (!prev && cur) : (prev && !cur);
    endfunction

    function automatic pcl_pkg::pcl_side_t stepSide(
        input pcl_pkg::pcl_side_t s,
        input logic in1,
        input logic in2,
        input logic isB,
        input logic selPort,
        input logic selCtrl,
        input logic rd,
        input logic [7:0] wd
    );
        pcl_pkg::pcl_side_t n;
        logic hit1;
        logic hit2;
        logic orAcc;
        logic clr;
        logic trig;
        n = s;
        // edges come from successive samples, enable bits play no part
        hit1 = edgeHit(s.prev1, in1, s.ctrl[`PCL_B_EDGE1]); // [R02] [R26]
        hit2 = !s.ctrl[`PCL_B_MODE] && edgeHit(s.prev2, in2, s.ctrl[`PCL_B_EDGE2]); // [R06]
        orAcc = selPort && s.ctrl[`PCL_B_ORSEL]; // [R04] [R15]
        clr = orAcc && rd;
        // side A strobes on reads, side B on writes
        trig = orAcc && (isB ? !rd : rd);
        n.prev1 = in1;
        n.prev2 = in2;
        if (clr) begin
            n.flag1 = 1'b0;
            n.flag2 = 1'b0;
        end
        // a set in the clearing cycle wins, so no edge is lost
        if (hit1) begin
            n.flag1 = 1'b1; // [R01] [R13]
        end
        if (hit2) begin
            n.flag2 = 1'b1; // [R05] [R16]
        end
        if (!rd && selCtrl) begin
            n.ctrl = wd[`PCL_CTRL_W-1:0];
        end
        if (!rd && selPort) begin
            if (s.ctrl[`PCL_B_ORSEL]) begin
                n.outReg = wd; // [R04] [R15]
            end else begin
                n.dirReg = wd;
            end
        end
        if (n.ctrl[`PCL_B_MODE]) begin
            n.flag2 = 1'b0; // [R08] [R18]
        end
        if (!n.ctrl[`PCL_B_MODE]) begin
            // undriven in input mode; idle level kept high
            n.line = `PCL_RST_LINE;
        end else if (n.ctrl[`PCL_B_EDGE2]) begin
            n.line = n.ctrl[`PCL_B_EN2]; // [R09] [R19]
        end else if (trig) begin
            n.line = 1'b0; // [R10] [R20]
        end else if (!s.line && s.ctrl[`PCL_B_EN2]) begin
            n.line = 1'b1; // [R11] [R21]
        end else if (!s.line && hit1) begin
            // the handshake relies on the peripheral producing this edge
            n.line = 1'b1; // [R12] [R22]
        end
        n.irqOe = (n.flag1 && n.ctrl[`PCL_B_EN1]) // [R03] [R14]
            || (n.flag2 && n.ctrl[`PCL_B_EN2]); // [R07] [R17]
        stepSide = n;
    endfunction

    function automatic logic [7:0] ctrlView(input pcl_pkg::pcl_side_t s);
        ctrlView = {s.flag1, s.flag2 && !s.ctrl[`PCL_B_MODE], s.ctrl}; // [R08] [R18]
    endfunction

    // ==========================================
    // state
    pcl_pkg::pcl_state_t st_reg;
    pcl_pkg::pcl_state_t st_next;
    pcl_pkg::pcl_regsel_t sel;
    logic isRead;
    logic isWrite;
    logic rdOrA;
    logic wrOrB;
    logic edgeA1;
    logic edgeB1;

    always_comb begin
        sel = pcl_pkg::pcl_regsel_t'({bus.regSelectHi, bus.regSelectLo}); // [R25]
        isRead = bus.access && bus.read;
        isWrite = bus.access && !bus.read;
        rdOrA = isRead && sel == pcl_pkg::SEL_PORT_A && st_reg.a.ctrl[`PCL_B_ORSEL];
        wrOrB = isWrite && sel == pcl_pkg::SEL_PORT_B && st_reg.b.ctrl[`PCL_B_ORSEL];
        edgeA1 = edgeHit(st_reg.a.prev1, sideAIrqInput, st_reg.a.ctrl[`PCL_B_EDGE1]);
        edgeB1 = edgeHit(st_reg.b.prev1, sideBIrqInput, st_reg.b.ctrl[`PCL_B_EDGE1]);
    end

    // ==========================================
    // next state
    always_comb begin
        st_next = st_reg;
        st_next.a = stepSide(st_reg.a, sideAIrqInput, sideACtrlLineIn, 1'b0,
            bus.access && sel == pcl_pkg::SEL_PORT_A,
            bus.access && sel == pcl_pkg::SEL_CTRL_A, bus.read, bus.wrData);
        st_next.b = stepSide(st_reg.b, sideBIrqInput, sideBCtrlLineIn, 1'b1,
            bus.access && sel == pcl_pkg::SEL_PORT_B,
            bus.access && sel == pcl_pkg::SEL_CTRL_B, bus.read, bus.wrData);
        if (isRead) begin
            case (sel) // [R25]
                pcl_pkg::SEL_PORT_A: begin
                    // side A reads the pins, whatever the output register holds
                    st_next.rdData = st_reg.a.ctrl[`PCL_B_ORSEL] ? portAIn : st_reg.a.dirReg;
                end
                pcl_pkg::SEL_CTRL_A: begin
                    st_next.rdData = ctrlView(st_reg.a);
                end
                pcl_pkg::SEL_PORT_B: begin
                    // side B returns its own register on output bits, immune to load
                    st_next.rdData = st_reg.b.ctrl[`PCL_B_ORSEL]
                        ? ((st_reg.b.dirReg & st_reg.b.outReg) | (~st_reg.b.dirReg & portBIn))
                        : st_reg.b.dirReg;
                end
                pcl_pkg::SEL_CTRL_B: begin
                    st_next.rdData = ctrlView(st_reg.b);
                end
                default: begin
                    st_next.rdData = `PCL_RST_BYTE;
                end
            endcase
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg.a.ctrl <= `PCL_RST_CTRL; // [R23]
            st_reg.a.flag1 <= 1'b0;
            st_reg.a.flag2 <= 1'b0;
            st_reg.a.outReg <= `PCL_RST_BYTE;
            st_reg.a.dirReg <= `PCL_RST_BYTE;
            st_reg.a.prev1 <= 1'b0;
            st_reg.a.prev2 <= 1'b0;
            st_reg.a.line <= `PCL_RST_LINE;
            st_reg.a.irqOe <= 1'b0;
            st_reg.b.ctrl <= `PCL_RST_CTRL; // [R23]
            st_reg.b.flag1 <= 1'b0;
            st_reg.b.flag2 <= 1'b0;
            st_reg.b.outReg <= `PCL_RST_BYTE;
            st_reg.b.dirReg <= `PCL_RST_BYTE;
            st_reg.b.prev1 <= 1'b0;
            st_reg.b.prev2 <= 1'b0;
            st_reg.b.line <= `PCL_RST_LINE;
            st_reg.b.irqOe <= 1'b0;
            st_reg.rdData <= `PCL_RST_BYTE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================
    // outputs, all from flip-flops except the constant request pull levels
    assign busRdData = st_reg.rdData;
    assign portAOut = st_reg.a.outReg;
    assign portAOe = st_reg.a.dirReg;
    assign portBOut = st_reg.b.outReg;
    assign portBOe = st_reg.b.dirReg;
    assign sideACtrlLineOut = st_reg.a.line;
    assign sideACtrlLineOe = st_reg.a.ctrl[`PCL_B_MODE]; // [R08]
    assign sideBCtrlLineOut = st_reg.b.line;
    assign sideBCtrlLineOe = st_reg.b.ctrl[`PCL_B_MODE]; // [R18]
    // open drain: only ever pulls low, so several requests may share a wire
    assign sideAIntRequestOut = `PCL_IRQ_LEVEL; // [R24]
    assign sideAIntRequestOe = st_reg.a.irqOe; // [R24]
    assign sideBIntRequestOut = `PCL_IRQ_LEVEL;
    assign sideBIntRequestOe = st_reg.b.irqOe;

    // ==========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_flag_a1_set: assert property (edgeA1 |=> st_reg.a.flag1) // [R01]
        else $error("side A line-1 flag not set after edge");
    a_flag_a1_clear: assert property (rdOrA && !edgeA1 |=> !st_reg.a.flag1) // [R01]
        else $error("side A line-1 flag not cleared by read");
    a_irq_a_mask: assert property (sideAIntRequestOe |-> // [R03]
        (st_reg.a.flag1 && st_reg.a.ctrl[`PCL_B_EN1])
        || (st_reg.a.flag2 && st_reg.a.ctrl[`PCL_B_EN2]))
        else $error("side A request without enabled flag");
    a_bit6_zero: assert property (st_reg.a.ctrl[`PCL_B_MODE] |-> !st_reg.a.flag2) // [R08]
        else $error("side A bit 6 set in output mode");
    a_manual_level: assert property ( // [R09]
        $past(st_reg.a.ctrl[`PCL_B_MODE] && st_reg.a.ctrl[`PCL_B_EDGE2])
        && $stable(st_reg.a.ctrl) |-> sideACtrlLineOut == st_reg.a.ctrl[`PCL_B_EN2])
        else $error("side A line 2 not at manual level");
    a_read_strobe: assert property ( // [R10]
        rdOrA && st_reg.a.ctrl[`PCL_B_MODE] && !st_reg.a.ctrl[`PCL_B_EDGE2]
        |=> !sideACtrlLineOut)
        else $error("side A line 2 not low after read");
    a_strobe_pulse: assert property ( // [R11]
        rdOrA && st_reg.a.ctrl[5:3] == 3'h5 ##1 !rdOrA && !isWrite
        |=> sideACtrlLineOut)
        else $error("side A strobe wider than one cycle");
    a_handshake_hold: assert property ( // [R12]
        !sideACtrlLineOut && st_reg.a.ctrl[5:3] == 3'h4 && !edgeA1 && !isWrite
        |=> !sideACtrlLineOut)
        else $error("side A line 2 released without line-1 edge");
    a_b_write_strobe: assert property ( // [R20]
        wrOrB && st_reg.b.ctrl[`PCL_B_MODE] && !st_reg.b.ctrl[`PCL_B_EDGE2]
        |=> !sideBCtrlLineOut)
        else $error("side B line 2 not low after write");
    a_b_flag_set: assert property (edgeB1 |=> st_reg.b.flag1) // [R13]
        else $error("side B line-1 flag not set after edge");

endmodule

// File: design/pcl_consts.svh
// Operation
// [R01] side A line-1 flag sets on chosen edge; cleared by output read or reset
// [R02] side A bit 1 picks line-1 edge: 1 rising, 0 falling
// [R03] side A request asserts from line-1 flag only while bit 0 is 1
// [R04] side A bit 2 routes shared address: 1 output register, 0 direction
// [R05] side A input mode: line-2 flag sets on chosen edge, cleared by read
// [R06] side A bit 4 picks line-2 edge in input mode: 1 rising
// [R07] side A request asserts from line-2 flag only while bit 3 is 1
// [R08] side A bit 5 set: line 2 driven, bit 6 reads zero
// [R09] side A manual mode: line 2 follows written bit 3
// [R10] side A strobe mode: line 2 goes low after output register read
// [R11] side A strobe with bit 3 set: line 2 returns high next cycle
// [R12] side A strobe with bit 3 clear: line 2 low until line-1 edge
// [R13] side B line-1 flag sets on chosen edge; cleared by output read or reset
// [R14] side B request asserts from line-1 flag only while bit 0 is 1
// [R15] side B bit 2 routes shared address: 1 output register, 0 direction
// [R16] side B input mode: line-2 flag sets on chosen edge, cleared by read
// [R17] side B request asserts from line-2 flag only while bit 3 is 1
// [R18] side B bit 5 set: line 2 driven, bit 6 reads zero
// [R19] side B manual mode: line 2 takes written bit 3
// [R20] side B strobe mode: line 2 goes low after output register write
// [R21] side B strobe with bit 3 set: line 2 returns high next cycle
// [R22] side B strobe with bit 3 clear: line 2 low until line-1 edge
// [R23] reset clears every internal register including both control registers; the line-2 output registers of both sides reset high
// [R24] each request is active low open drain, wire-or capable
// [R25] select 0 port A, 1 control A, 2 port B, 3 control B
// [R26] inputs sampled each clock, edges from successive samples, flags ignore enables
`ifndef PCL_CONSTS_SVH
`define PCL_CONSTS_SVH

// ==========================================
// control register fields
`define PCL_B_EN1 0
`define PCL_B_EDGE1 1
`define PCL_B_ORSEL 2
`define PCL_B_EN2 3
`define PCL_B_EDGE2 4
`define PCL_B_MODE 5
`define PCL_CTRL_W 6

// ==========================================
// reset values
`define PCL_RST_CTRL 6'h00
`define PCL_RST_BYTE 8'h00
`define PCL_RST_LINE 1'b1
`define PCL_IRQ_LEVEL 1'b0

`endif

// File: design/pcl_pkg.sv
package pcl_pkg;

    // register select decode
    typedef enum logic [1:0] {
        SEL_PORT_A,
        SEL_CTRL_A,
        SEL_PORT_B,
        SEL_CTRL_B
    } pcl_regsel_t;

    // processor side access, one cycle per access
    typedef struct packed {
        logic access;
        logic read;
        logic regSelectHi;
        logic regSelectLo;
        logic [7:0] wrData;
    } pcl_bus_t;

    // state of one side
    typedef struct packed {
        logic [5:0] ctrl;
        logic flag1;
        logic flag2;
        logic [7:0] outReg;
        logic [7:0] dirReg;
        logic prev1;
        logic prev2;
        logic line;
        logic irqOe;
    } pcl_side_t;

    typedef struct packed {
        pcl_side_t a;
        pcl_side_t b;
        logic [7:0] rdData;
    } pcl_state_t;

endpackage

// File: testbench/pcl_periph_model.sv
`timescale 1ns/100ps
// ==========================================
// far-side peripheral: drives line 1 and answers a held strobe
module pcl_periph_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // bench control
    input wire logic tbLvl,
    input wire logic autoAck,
    input wire logic rising,
    input wire logic [3:0] ackDelay,
    // control line 2 from the design
    input wire logic lineOut,
    input wire logic lineOe,
    // line 1 toward the design
    output logic line1
);
    logic [1:0] state_reg;
    logic [3:0] count_reg;
    logic ackLevel_reg;
    // line 1 is driven at all times, so it never floats
    assign line1 = autoAck ? ackLevel_reg : tbLvl;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= 2'h0;
            count_reg <= 4'h0;
            ackLevel_reg <= 1'b1;
        end else begin
            case (state_reg)
                2'h0: if (autoAck && lineOe && !lineOut) begin
                    state_reg <= 2'h1;
                    count_reg <= ackDelay;
                    ackLevel_reg <= ~rising;
                end
                2'h1: if (count_reg != 4'h0) begin
                    count_reg <= count_reg - 4'h1;
                end else begin
                    // a slow answer keeps the strobe low for the whole delay
                    ackLevel_reg <= rising;
                    state_reg <= 2'h2;
                end
                default: if (lineOut) begin
                    state_reg <= 2'h0;
                end
            endcase
        end
    end
endmodule

// File: testbench/pcl_port_ctrl_tb.sv
`timescale 1ns/100ps
module pcl_port_ctrl_tb;
    logic clk;
    logic sys_rst;
    pcl_pkg::pcl_bus_t bus;
    logic [7:0] busRdData;
    logic [7:0] pinIn [2];
    logic [7:0] portOut [2];
    logic [7:0] portOe [2];
    logic [1:0] lvl1, lvl2, rise1, ack, line1, lineIn, lineOut, lineOe, reqOe, reqOut;
    logic [3:0] ackDly [2];
    logic [7:0] rdv, dirV, outV;
    logic [5:0] c;
    logic [1:0] e;
    logic s;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int seed;
    int n;
    // ==========================================
    // design and far side
    pcl_port_ctrl i_pcl_port_ctrl (.clk(clk), .sys_rst(sys_rst), .bus(bus),
        .busRdData(busRdData), .portAIn(pinIn[0]), .portAOut(portOut[0]), .portAOe(portOe[0]),
        .portBIn(pinIn[1]), .portBOut(portOut[1]), .portBOe(portOe[1]),
        .sideAIrqInput(line1[0]), .sideACtrlLineIn(lineIn[0]),
        .sideACtrlLineOut(lineOut[0]), .sideACtrlLineOe(lineOe[0]),
        .sideBIrqInput(line1[1]), .sideBCtrlLineIn(lineIn[1]),
        .sideBCtrlLineOut(lineOut[1]), .sideBCtrlLineOe(lineOe[1]),
        .sideAIntRequestOut(reqOut[0]), .sideAIntRequestOe(reqOe[0]),
        .sideBIntRequestOut(reqOut[1]), .sideBIntRequestOe(reqOe[1]));
    for (genvar g = 0; g < 2; g++) begin : g_side
        // the wire shows the design's level while it drives, else the bench's
        assign lineIn[g] = lineOe[g] ? lineOut[g] : lvl2[g];
        pcl_periph_model i_pcl_periph_model (.clk(clk), .sys_rst(sys_rst), .tbLvl(lvl1[g]),
            .autoAck(ack[g]), .rising(rise1[g]), .ackDelay(ackDly[g]),
            .lineOut(lineOut[g]), .lineOe(lineOe[g]), .line1(line1[g]));
    end
    // ==========================================
    // helpers
    task automatic close_out();
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp, input string what);
        cmp8({7'h00, got}, {7'h00, exp}, what);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic acc(input logic rd, input logic [1:0] sel, input logic [7:0] wd);
        bus = {1'b1, rd, sel, wd};
        cyc(1);
        bus = 12'h000;
        rdv = busRdData;
    endtask
    function automatic logic [7:0] expCtrl(input logic f1, input logic f2, input logic [5:0] cr);
        return {f1, f2 & ~cr[5], cr};
    endfunction
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        seed = 32'h90aa;
        bus = 12'h000;
        pinIn[0] = 8'h00;
        pinIn[1] = 8'h00;
        lvl1 = 2'b11;
        lvl2 = 2'b11;
        rise1 = 2'b00;
        ack = 2'b00;
        ackDly[0] = 4'h1;
        ackDly[1] = 4'h1;
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        for (int j = 0; j < 2; j++) begin
            s = j[0];
            acc(1'b1, {s, 1'b1}, 8'h00);
            cmp8(rdv, 8'h00, "ctrl reset");
            cmp1(lineOut[s] & ~lineOe[s] & ~reqOe[s], 1'b1, "lines idle");
            cmp1(reqOut[s], 1'b0, "request pull level");
            dirV = 8'($random(seed));
            outV = 8'($random(seed));
            pinIn[s] = 8'($random(seed));
            acc(1'b0, {s, 1'b0}, dirV);
            acc(1'b0, {s, 1'b1}, 8'hC4);
            acc(1'b0, {s, 1'b0}, outV);
            acc(1'b1, {s, 1'b0}, 8'h00);
            cmp8(rdv, s ? ((outV & dirV) | (pinIn[s] & ~dirV)) : pinIn[s], "port");
            cmp8(portOe[s], dirV, "direction");
            cmp8(portOut[s], outV, "output");
            acc(1'b1, {s, 1'b1}, 8'h00);
            cmp8(rdv, 8'h04, "ctrl readback");
            acc(1'b0, {s, 1'b1}, 8'h00);
            acc(1'b1, {s, 1'b0}, 8'h00);
            cmp8(rdv, dirV, "direction read");
        end
        for (int i = 0; i < 32; i++) begin
            {e, c, s} = 9'($random(seed));
            c[2] = 1'b1;
            c[4] = c[4] | c[5];
            lvl1[s] = ~c[1];
            lvl2[s] = ~c[4];
            acc(1'b0, {s, 1'b1}, {2'b00, c});
            cyc(3);
            acc(1'b1, {s, 1'b0}, 8'h00);
            if (e[0]) lvl1[s] = c[1];
            if (e[1]) lvl2[s] = c[4];
            cyc(3);
            cmp1(reqOe[s], (e[0] & c[0]) | (e[1] & ~c[5] & c[3]), "request");
            acc(1'b1, {s, 1'b1}, 8'h00);
            cmp8(rdv, expCtrl(e[0], e[1], c), "flags");
            acc(1'b1, {s, 1'b0}, 8'h00);
            acc(1'b1, {s, 1'b1}, 8'h00);
            cmp8(rdv, expCtrl(1'b0, 1'b0, c), "flag clear");
        end
        for (int k = 0; k < 4; k++) begin
            acc(1'b0, {k[1], 1'b1}, {4'h3, k[0], 3'h4});
            cyc(1);
            cmp1(lineOut[k[1]], k[0], "manual");
            cmp1(lineOe[k[1]], 1'b1, "driven");
        end
        for (int j = 0; j < 2; j++) begin
            s = j[0];
            acc(1'b0, {s, 1'b1}, 8'h2C);
            acc(~s, {s, 1'b0}, 8'h5A);
            cmp1(lineOut[s], 1'b0, "strobe low");
            cyc(1);
            cmp1(lineOut[s], 1'b1, "strobe high");
            // the opposite access kind must not fire this side's strobe
            acc(s, {s, 1'b0}, 8'h00);
            cmp1(lineOut[s], 1'b1, "no strobe");
        end
        for (int k = 0; k < 4; k++) begin
            s = k[0];
            ackDly[s] = k[1] ? 4'h8 : 4'h1;
            rise1[s] = 1'b0;
            ack[s] = 1'b1;
            acc(1'b0, {s, 1'b1}, 8'h24);
            acc(~s, {s, 1'b0}, 8'hA5);
            n = 0;
            while (lineOut[s] !== 1'b1 && n < 40) begin
                cyc(1);
                n++;
            end
            cmp1(n > ackDly[s] && n < ackDly[s] + 8, 1'b1, "held strobe");
            lvl1[s] = 1'b0;
            ack[s] = 1'b0;
            acc(1'b1, {s, 1'b1}, 8'h00);
            cmp8(rdv, expCtrl(1'b1, 1'b0, 6'h24), "ack flag");
        end
        close_out();
    end
endmodule
